// ### rtl/epm_map.sv
// Visible-to-physical EEPROM address mapper
`timescale 1ns/1ps
`default_nettype none
module epm_map
  import epm_pkg::*;
(
  input  wire logic [VIS_AW-1:0]  addr_i,
  input  wire logic               page_sel_i,
  input  wire logic               sector_mode_i,
  output logic      [PHYS_AW-1:0] phys_idx_o,
  output logic      [SEC_W-1:0]   phys_sec_o
);

  always_comb begin
    if (sector_mode_i) begin
      // Whole sector in one page; page bit picks the sector set
      phys_idx_o = {page_sel_i, addr_i};  // R05 R01
    end else begin
      // Half sector visible; page bit picks which half
      phys_idx_o = {addr_i[4:2], page_sel_i, addr_i[1:0]};  // R03 R01
    end
    // Same sector field in both modes gives full-split or foreground-only erase
    phys_sec_o = phys_idx_o[PHYS_AW-1:PHYS_AW-SEC_W];  // R02 R04 R06
  end

endmodule
`default_nettype wire

// ### rtl/epm_pkg.sv
// Constants and carrier types for the EEPROM page mapping block
// What this block does
// R01: Only one half of the EEPROM array is visible at a time, chosen by the page-select bit.
// R02: The array is kept in 8-byte sectors, mapped in 4-byte or 8-byte mode by the sector-mode bit.
// R03: With sector mode 0 each sector shows four of its bytes, the page-select bit picking which.
// R04: In 4-byte mode a sector erase clears all eight bytes, foreground and background.
// R05: With sector mode 1 a whole sector lives in one page, the page-select bit picking the page.
// R06: In 8-byte mode a sector erase clears only the foreground sector.
// R07: Seven byte-wide control registers plus three nonvolatile locations are provided.
// R08: At reset two nonvolatile locations are copied into their control registers.
// R09: An 8-byte comparison key held in flash is kept and compared against.
// R10: The clock divider must be written once before any erase or program; later writes are ignored.
// R11: A new page-select value applies from the very next EEPROM access.
package epm_pkg;

  localparam int unsigned VIS_AW   = 5;
  localparam int unsigned PHYS_AW  = 6;
  localparam int unsigned SEC_W    = 3;
  localparam int unsigned PHYS_N   = 64;
  localparam int unsigned HP_N     = 7;
  localparam int unsigned KEY_W    = 64;

  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Control register indices
  localparam logic [2:0] HP_DIV  = 3'h0;
  localparam logic [2:0] HP_OPT  = 3'h1;
  localparam logic [2:0] HP_CFG  = 3'h2;
  localparam logic [2:0] HP_RSV  = 3'h3;
  localparam logic [2:0] HP_PROT = 3'h4;
  localparam logic [2:0] HP_STAT = 3'h5;
  localparam logic [2:0] HP_CMD  = 3'h6;

  // Field positions
  localparam int unsigned DIV_DONE_BIT  = 7;
  localparam int unsigned OPT_MODE_BIT  = 0;
  localparam int unsigned CFG_PAGE_BIT  = 0;
  localparam int unsigned STAT_ERR_BIT  = 0;
  localparam int unsigned STAT_CMPL_BIT = 1;

  localparam logic [7:0] HP_RESET = 8'h00;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic              erase;
    logic [VIS_AW-1:0] addr;
    logic [7:0]        wdata;
  } epm_req_s;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] idx;
    logic [7:0] wdata;
  } epm_hp_req_s;

endpackage

// ### rtl/epm_top.sv
// EEPROM page mapping with control registers and comparison key
`timescale 1ns/1ps
`default_nettype none
module epm_top
  import epm_pkg::*;
(
  input  wire logic              CLK_SYS_I,
  input  wire logic              RST_N_I,
  input  wire epm_req_s          EE_REQ_I,
  output logic      [7:0]        EE_RDATA_O,
  output logic                   EE_DONE_O,
  output logic                   EE_ERR_O,
  input  wire epm_hp_req_s       HP_REQ_I,
  output logic      [7:0]        HP_RDATA_O,
  input  wire logic [7:0]        NV_OPTION_I,
  input  wire logic [7:0]        NV_PROT_I,
  input  wire logic [KEY_W-1:0]  NV_KEY_I,
  input  wire logic [KEY_W-1:0]  KEY_CMP_I,
  input  wire logic              KEY_CHECK_I,
  output logic                   KEY_MATCH_O,
  output logic                   PAGE_SEL_O,
  output logic                   SECTOR_MODE_O
);

  logic [7:0]         mem_q [PHYS_N];
  logic [7:0]         mem_d [PHYS_N];
  logic [7:0]         hp_q  [HP_N];
  logic [7:0]         hp_d  [HP_N];
  logic [KEY_W-1:0]   key_q;
  logic [7:0]         rdata_q;
  logic [7:0]         rdata_d;
  logic               done_q;
  logic               done_d;
  logic               err_q;
  logic               err_d;
  logic [7:0]         hp_rdata_q;
  logic [7:0]         hp_rdata_d;
  logic               match_q;
  logic               match_d;
  logic [PHYS_AW-1:0] phys_idx;
  logic [SEC_W-1:0]   phys_sec;
  logic               eeprom_page_select;
  logic               eeprom_sector_mode;
  logic               div_written;
  logic               nv_op;
  logic               op_ok;
  logic               op_err;

  // Live register values: a page change applies to the next access
  assign eeprom_page_select = hp_q[HP_CFG][CFG_PAGE_BIT];  // R11 R01
  assign eeprom_sector_mode = hp_q[HP_OPT][OPT_MODE_BIT];  // R02
  assign div_written        = hp_q[HP_DIV][DIV_DONE_BIT];

  epm_map u_map (
    .addr_i        (EE_REQ_I.addr),
    .page_sel_i    (eeprom_page_select),
    .sector_mode_i (eeprom_sector_mode),
    .phys_idx_o    (phys_idx),
    .phys_sec_o    (phys_sec)
  );

  // Erase and program refused until the divider is set
  assign nv_op  = EE_REQ_I.wr | EE_REQ_I.erase;
  assign op_ok  = nv_op & div_written;  // R10
  assign op_err = nv_op & ~div_written;  // R10

  // Array storage: erase takes priority over a program in the same cycle
  for (genvar gi = 0; gi < PHYS_N; gi++) begin : g_mem
    localparam logic [PHYS_AW-1:0] IDX = gi[PHYS_AW-1:0];
    always_comb begin
      mem_d[gi] = mem_q[gi];
      if (op_ok && EE_REQ_I.erase) begin
        if (IDX[PHYS_AW-1:PHYS_AW-SEC_W] == phys_sec) begin
          mem_d[gi] = ERASED_BYTE;  // R04 R06
        end
      end else if (op_ok && EE_REQ_I.wr && IDX == phys_idx) begin
        mem_d[gi] = EE_REQ_I.wdata;  // R03 R05
      end
    end
    always_ff @(posedge CLK_SYS_I) begin
      if (!RST_N_I) begin
        mem_q[gi] <= ERASED_BYTE;
      end else begin
        mem_q[gi] <= mem_d[gi];
      end
    end
  end

  // Access answer path
  always_comb begin
    rdata_d = rdata_q;
    done_d  = 1'b0;
    err_d   = op_err;
    if (EE_REQ_I.rd) begin
      // Only the foreground byte is reachable
      rdata_d = mem_q[phys_idx];  // R01
      done_d  = 1'b1;
    end
    if (op_ok) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      rdata_q <= HP_RESET;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      done_q  <= done_d;
      err_q   <= err_d;
    end
  end

  // Seven control registers
  always_comb begin
    for (int i = 0; i < HP_N; i++) begin
      hp_d[i] = hp_q[i];
    end
    if (HP_REQ_I.wr) begin
      unique case (HP_REQ_I.idx)
        HP_DIV: begin
          // One write only; the flag locks bits 6:0
          if (!div_written) begin
            hp_d[HP_DIV] = {1'b1, HP_REQ_I.wdata[6:0]};  // R10
          end
        end
        HP_CFG: begin
          hp_d[HP_CFG] = HP_REQ_I.wdata;  // R11
        end
        HP_STAT: begin
          // Write one to clear the error flag
          if (HP_REQ_I.wdata[STAT_ERR_BIT]) begin
            hp_d[HP_STAT][STAT_ERR_BIT] = 1'b0;
          end
        end
        HP_CMD: begin
          hp_d[HP_CMD] = HP_REQ_I.wdata;
        end
        // Option and protection copies are read-only
        default: begin
        end
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (op_err) begin
      hp_d[HP_STAT][STAT_ERR_BIT] = 1'b1;
    end
    hp_d[HP_STAT][STAT_CMPL_BIT] = 1'b1;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      for (int i = 0; i < HP_N; i++) begin
        hp_q[i] <= HP_RESET;  // R07
      end
      // Nonvolatile settings become live at every reset
      hp_q[HP_OPT]  <= NV_OPTION_I;  // R08
      hp_q[HP_PROT] <= NV_PROT_I;  // R08
    end else begin
      for (int i = 0; i < HP_N; i++) begin
        hp_q[i] <= hp_d[i];
      end
    end
  end

  // Register readback; reserved index 3 and index 7 read zero
  always_comb begin
    hp_rdata_d = hp_rdata_q;
    if (HP_REQ_I.rd) begin
      if (HP_REQ_I.idx == HP_RSV || HP_REQ_I.idx > HP_CMD) begin
        hp_rdata_d = HP_RESET;
      end else begin
        hp_rdata_d = hp_q[HP_REQ_I.idx];  // R07
      end
    end
  end

  // Comparison key copied from flash at reset
  always_comb begin
    match_d = match_q;
    if (KEY_CHECK_I) begin
      match_d = (KEY_CMP_I == key_q);  // R09
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RST_N_I) begin
      key_q      <= NV_KEY_I;  // R09
      hp_rdata_q <= HP_RESET;
      match_q    <= 1'b0;
    end else begin
      key_q      <= key_q;
      hp_rdata_q <= hp_rdata_d;
      match_q    <= match_d;
    end
  end

  assign EE_RDATA_O    = rdata_q;
  assign EE_DONE_O     = done_q;
  assign EE_ERR_O      = err_q;
  assign HP_RDATA_O    = hp_rdata_q;
  assign KEY_MATCH_O   = match_q;
  assign PAGE_SEL_O    = hp_q[HP_CFG][CFG_PAGE_BIT];
  assign SECTOR_MODE_O = hp_q[HP_OPT][OPT_MODE_BIT];

endmodule
`default_nettype wire

// ### testbench/epm_checker.sv
// Port assertions for the EEPROM page mapping block
`timescale 1ns/1ps
`default_nettype none
module epm_checker
  import epm_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        RST_N_I,
  input wire epm_req_s    EE_REQ_I,
  input wire epm_hp_req_s HP_REQ_I,
  input wire logic [7:0]  EE_RDATA_O,
  input wire logic [7:0]  HP_RDATA_O,
  input wire logic        EE_DONE_O,
  input wire logic        EE_ERR_O,
  input wire logic        KEY_CHECK_I,
  input wire logic        KEY_MATCH_O,
  input wire logic        PAGE_SEL_O,
  input wire logic        SECTOR_MODE_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);
  wire logic any_w = EE_REQ_I.wr | EE_REQ_I.erase;
  wire logic cfg_w = HP_REQ_I.wr && (HP_REQ_I.idx == HP_CFG);
  property p_rd; EE_REQ_I.rd |=> EE_DONE_O; endproperty
  a_rd: assert property (p_rd) else $error("read not acknowledged");
  property p_wr; any_w |=> (EE_DONE_O != EE_ERR_O); endproperty
  a_wr: assert property (p_wr) else $error("write without one answer");
  property p_hold; !EE_REQ_I.rd |=> $stable(EE_RDATA_O); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_mode; $stable(SECTOR_MODE_O); endproperty
  a_mode: assert property (p_mode) else $error("sector mode moved");
  property p_page; cfg_w |=> PAGE_SEL_O == $past(HP_REQ_I.wdata[0]); endproperty
  a_page: assert property (p_page) else $error("page select not taken");
  property p_pgst; !cfg_w |=> $stable(PAGE_SEL_O); endproperty
  a_pgst: assert property (p_pgst) else $error("page select moved");
  property p_key; !KEY_CHECK_I |=> $stable(KEY_MATCH_O); endproperty
  a_key: assert property (p_key) else $error("key result moved");
  property p_rsv; HP_REQ_I.rd && HP_REQ_I.idx == HP_RSV |=> HP_RDATA_O == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved reads nonzero");
  c_err: cover property (EE_REQ_I.wr ##1 EE_ERR_O);
  c_ers: cover property (EE_REQ_I.erase ##1 EE_DONE_O);
  c_key: cover property (KEY_CHECK_I ##1 KEY_MATCH_O);
endmodule
bind epm_top epm_checker u_chk (.*);
`default_nettype wire

// ### testbench/epm_cpu_model.sv
// Bus-side request model standing in for the processor
`timescale 1ns/1ps
`default_nettype none
module epm_cpu_model
  import epm_pkg::*;
(
  input  wire logic        clk_i,
  output var  epm_req_s    ee_o,
  output var  epm_hp_req_s hp_o
);
  initial begin
    ee_o = '0;
    hp_o = '0;
  end
  // One request per call, held across exactly one sampling edge
  task automatic ee_op(input logic [2:0] c, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk_i);
    ee_o = '{c[2], c[1], c[0], a, d};
    @(negedge clk_i);
    ee_o = '{1'b0, 1'b0, 1'b0, ~a, ~d}; // Released lines show no stale value
  endtask
  task automatic hp_op(input logic w, input logic r, input logic [2:0] i, input logic [7:0] d);
    @(negedge clk_i);
    hp_o = '{w, r, i, d};
    @(negedge clk_i);
    hp_o = '{1'b0, 1'b0, ~i, ~d};
  endtask
endmodule
`default_nettype wire

// ### testbench/epm_top_tb.sv
// Self-checking bench for the EEPROM page mapping block
`timescale 1ns/1ps
`default_nettype none
module epm_top_tb
  import epm_pkg::*;
;
  `define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
  logic             clk, rst_n, key_chk, done, err, key_m, pg, md;
  logic [7:0]       nv_opt, rdata, hp_rd, d;
  logic [5:0]       s;
  logic [KEY_W-1:0] nv_key, key_cmp;
  epm_req_s         ee;
  epm_hp_req_s      hp;
  logic [7:0]       mem [PHYS_N];
  int               seed = 56803, fail_count = 0, checks_done = 0, cyc = 0;
  epm_cpu_model u_cpu (.clk_i(clk), .ee_o(ee), .hp_o(hp));
  epm_top dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .EE_REQ_I(ee), .EE_RDATA_O(rdata),
    .EE_DONE_O(done), .EE_ERR_O(err), .HP_REQ_I(hp), .HP_RDATA_O(hp_rd),
    .NV_OPTION_I(nv_opt), .NV_PROT_I(8'h00), .NV_KEY_I(nv_key), .KEY_CMP_I(key_cmp),
    .KEY_CHECK_I(key_chk), .KEY_MATCH_O(key_m), .PAGE_SEL_O(pg), .SECTOR_MODE_O(md));
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [5:0] ph(input logic [4:0] a, input logic p, input logic m);
    return m ? {p, a} : {a[4:2], p, a[1:0]};
  endfunction
  task automatic setpg(input logic p);
    u_cpu.hp_op(1'b1, 1'b0, HP_CFG, {7'h0, p});
    `CHK("page", p, pg)
  endtask
  task automatic rd_all(input logic p, input logic m);
    setpg(p);
    for (int a = 0; a < 32; a++) begin
      u_cpu.ee_op(3'b100, a[4:0], 8'h00);
      `CHK("rdata", mem[ph(a[4:0], p, m)], rdata)
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Far above the roughly 1150 cycles the sequence needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    {rst_n, key_chk, nv_opt, nv_key, key_cmp} = '0;
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      rst_n = 1'b0;
      nv_opt = 8'($random(seed));
      nv_opt[0] = m[0];
      nv_key = {$random(seed), $random(seed)};
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      foreach (mem[i]) mem[i] = ERASED_BYTE;
      `CHK("mode", m[0], md)
      u_cpu.ee_op(3'b010, 5'h03, 8'h5a);
      `CHK("err", 1'b1, err)
      u_cpu.hp_op(1'b1, 1'b0, HP_DIV, 8'h12);
      u_cpu.hp_op(1'b1, 1'b0, HP_DIV, 8'h34);
      u_cpu.hp_op(1'b0, 1'b1, HP_DIV, 8'h00);
      `CHK("div", 8'h92, hp_rd)
      u_cpu.hp_op(1'b0, 1'b1, HP_RSV, 8'h00);
      `CHK("rsv", 8'h00, hp_rd)
      for (int k = 0; k < 2; k++) begin
        @(negedge clk);
        key_cmp = nv_key ^ KEY_W'(k);
        key_chk = 1'b1;
        @(negedge clk);
        key_chk = 1'b0;
        `CHK("key", k == 0, key_m)
      end
      for (int p = 0; p < 2; p++) begin
        setpg(p[0]);
        for (int a = 0; a < 32; a++) begin
          d = 8'($random(seed));
          u_cpu.ee_op(3'b010, a[4:0], d);
          mem[ph(a[4:0], p[0], m[0])] = d;
        end
      end
      for (int e = 0; e < 3; e++) begin
        rd_all(1'b0, m[0]);
        rd_all(1'b1, m[0]);
        d = 8'($random(seed));
        setpg(d[7]);
        u_cpu.ee_op(3'b001, d[4:0], 8'h00);
        s = ph(d[4:0], d[7], m[0]);
        for (int i = 0; i < 8; i++) mem[{s[5:3], i[2:0]}] = ERASED_BYTE;
      end
    end
    results();
  end
endmodule
`default_nettype wire
